/* File: design/motor_pin_control.sv */
// Pin-level control and monitoring front end of a sensorless motor driver.
// Assumes config from an I2C target elsewhere; pins are asynchronous.
`timescale 1ns/1ns
module motor_pin_control
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Pins
    input wire logic brake_pin,
    input wire logic dir_pin,
    input wire logic drive_disable_input,
    input wire logic speed_wake_active,
    input wire logic [7:0] speed_cmd,
    // Configuration from the I2C target
    input wire motor_pins_pkg::cfg_t cfg,
    // Core state inputs
    input wire logic [7:0] motor_speed,
    input wire logic [7:0] duty_out,
    input wire logic fault_actionable,
    input wire logic fault_report_only,
    // Drive outputs
    output motor_pins_pkg::drive_t drive,
    output logic [7:0] speed_out,
    output logic sleep_req,
    output logic wake_req,
    // Monitoring outputs
    output logic [7:0] monitor_output_one,
    output logic [7:0] monitor_output_two,
    output logic speed_pulse_output,
    output logic fault_indicator_n,
    output logic alarm_out,
    output logic alarm_oe,
    // Regulator settings
    output motor_pins_pkg::reg_t regulator
);
    import motor_pins_pkg::*;

    // Pin synchronisers
    logic [2:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
    always_comb begin
        nxt_sync1 = {brake_pin, dir_pin, drive_disable_input};
        nxt_sync2 = sync1_ff;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
        end
    end

    logic brake_eff, dir_eff, off_s;
    assign brake_eff = cfg.brake_ovr_en ? cfg.brake_ovr : sync2_ff[2];
    assign dir_eff = cfg.dir_ovr_en ? cfg.dir_ovr : sync2_ff[1];
    assign off_s = sync2_ff[0];

    // Drive state machine
    drive_state_t st_ff, nxt_st;
    logic [7:0] spd_ff, nxt_spd;
    logic restart_ff, nxt_restart;
    always_comb begin
        nxt_st = st_ff;
        nxt_spd = spd_ff;
        nxt_restart = 1'b0;
        case (st_ff)
            ST_RUN: begin
                nxt_spd = speed_cmd;
                if (off_s) begin
                    nxt_st = ST_COAST;
                end else if (brake_eff) begin
                    nxt_st = ST_SLOW;
                end
            end
            ST_SLOW: begin
                if (off_s) begin
                    nxt_st = ST_COAST;
                end else if (!brake_eff) begin
                    nxt_st = ST_RUN;
                end else if (spd_ff > cfg.brake_speed_limit) begin
                    nxt_spd = spd_ff - 8'h01;
                end else begin
                    nxt_st = ST_BRAKE;
                end
            end
            ST_BRAKE: begin
                nxt_spd = 8'h00;
                if (off_s) begin
                    nxt_st = ST_COAST;
                end else if (!brake_eff) begin
                    nxt_st = ST_RUN;
                end
            end
            ST_COAST: begin
                nxt_spd = 8'h00;
                if (!off_s) begin
                    nxt_st = ST_RUN;
                    nxt_restart = 1'b1;
                end
            end
            default: nxt_st = ST_RUN;
        endcase
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= ST_RUN;
            spd_ff <= SPEED_RST;
            restart_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            spd_ff <= nxt_spd;
            restart_ff <= nxt_restart;
        end
    end

    // Commutation step counter, advanced each PWM cycle except in coast and brake
    logic [9:0] pwm_cnt_ff, nxt_pwm_cnt;
    logic [1:0] step_ff, nxt_step;
    logic pwm_tick;
    assign pwm_tick = (pwm_cnt_ff == PWM_CYCLES_W);
    always_comb begin
        nxt_pwm_cnt = pwm_tick ? 10'h000 : pwm_cnt_ff + 10'h001;
        nxt_step = step_ff;
        if (pwm_tick && st_ff != ST_COAST && st_ff != ST_BRAKE) begin
            nxt_step = (step_ff == 2'h2) ? 2'h0 : step_ff + 2'h1;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwm_cnt_ff <= 10'h000;
            step_ff <= 2'h0;
        end else begin
            pwm_cnt_ff <= nxt_pwm_cnt;
            step_ff <= nxt_step;
        end
    end

    logic [2:0] phase;
    always_comb begin
        case (step_ff)
            2'h0: phase = 3'h1;
            2'h1: phase = dir_eff ? 3'h2 : 3'h4;
            2'h2: phase = dir_eff ? 3'h4 : 3'h2;
            default: phase = 3'h1;
        endcase
    end

    assign drive.coast = (st_ff == ST_COAST);
    assign drive.low_side_brake = (st_ff == ST_BRAKE) && !cfg.brake_align;
    assign drive.align_brake = (st_ff == ST_BRAKE) && cfg.brake_align;
    assign drive.restart = restart_ff;
    assign drive.phase_high = (st_ff == ST_COAST || st_ff == ST_BRAKE) ? 3'h0 : phase;
    assign speed_out = spd_ff;
    assign sleep_req = !speed_wake_active;
    assign wake_req = speed_wake_active;

    // Monitor outputs
    logic [7:0] mon1_ff, mon2_ff, nxt_mon1, nxt_mon2;
    function automatic logic [7:0] mon_sel(input logic [1:0] a, input logic [7:0] s,
                                           input logic [7:0] m, input logic [7:0] d);
        case (a)
            2'h0: mon_sel = s;
            2'h1: mon_sel = m;
            2'h2: mon_sel = d;
            default: mon_sel = {6'h00, st_ff};
        endcase
    endfunction
    always_comb begin
        nxt_mon1 = mon1_ff;
        nxt_mon2 = mon2_ff;
        if (pwm_tick) begin
            nxt_mon1 = mon_sel(cfg.monitor_one_variable_address, spd_ff, motor_speed,
                               duty_out);
            nxt_mon2 = mon_sel(cfg.monitor_two_variable_address, spd_ff, motor_speed,
                               duty_out);
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mon1_ff <= MON_RST;
            mon2_ff <= MON_RST;
        end else begin
            mon1_ff <= nxt_mon1;
            mon2_ff <= nxt_mon2;
        end
    end
    assign monitor_output_one = mon1_ff;
    assign monitor_output_two = mon2_ff;

    // Speed pulses: phase accumulator stepping by motor speed
    logic [15:0] acc_ff, nxt_acc;
    logic fg_ff, nxt_fg;
    always_comb begin
        nxt_acc = acc_ff + {8'h00, motor_speed};
        nxt_fg = acc_ff[15];
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_ff <= 16'h0000;
            fg_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            fg_ff <= nxt_fg;
        end
    end
    assign speed_pulse_output = fg_ff;

    // Fault reporting
    logic fault_n_ff, alarm_ff, nxt_fault_n, nxt_alarm;
    always_comb begin
        if (cfg.alarm_enable) begin
            nxt_alarm = fault_actionable || fault_report_only;
            nxt_fault_n = !fault_actionable;
        end else begin
            nxt_alarm = 1'b0;
            nxt_fault_n = !(fault_actionable || fault_report_only);
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_n_ff <= 1'b1;
            alarm_ff <= 1'b0;
        end else begin
            fault_n_ff <= nxt_fault_n;
            alarm_ff <= nxt_alarm;
        end
    end
    assign fault_indicator_n = fault_n_ff;
    assign alarm_out = alarm_ff;
    assign alarm_oe = cfg.alarm_enable;

    // Regulator settings
    assign regulator.buck_vout = cfg.regulator_voltage_select;
    assign regulator.buck_ilim_ma = cfg.regulator_current_limit_select ?
        ILIM_LO_MA : ILIM_HI_MA;
    assign regulator.handover_on = !cfg.supply_handover_disable &&
        (cfg.regulator_voltage_select == VSEL_5V0 ||
         cfg.regulator_voltage_select == VSEL_5V7);

    // Checks
    property p_brake_hold;
        @(posedge clk) disable iff (!rst_b)
        (st_ff == ST_BRAKE && brake_eff && !off_s) |=> st_ff == ST_BRAKE;
    endproperty
    a_brake_hold: assert property (p_brake_hold) else $error("brake left early");
    property p_brake_type;
        @(posedge clk) disable iff (!rst_b)
        st_ff == ST_BRAKE |-> drive.align_brake == cfg.brake_align;
    endproperty
    a_brake_type: assert property (p_brake_type) else $error("brake type wrong");
    property p_slow;
        @(posedge clk) disable iff (!rst_b)
        $rose(st_ff == ST_BRAKE) |-> speed_out <= cfg.brake_speed_limit;
    endproperty
    a_slow: assert property (p_slow) else $error("braked above limit");
    property p_coast;
        @(posedge clk) disable iff (!rst_b)
        $rose(off_s) |-> ##[1:2] drive.coast && drive.phase_high == 3'h0;
    endproperty
    a_coast: assert property (p_coast) else $error("no coast");
    property p_restart;
        @(posedge clk) disable iff (!rst_b)
        (st_ff == ST_COAST && !off_s) |=> drive.restart;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");
    property p_fault;
        @(posedge clk) disable iff (!rst_b)
        (!cfg.alarm_enable && fault_report_only) |=> !fault_indicator_n;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not shown");
    property p_ro;
        @(posedge clk) disable iff (!rst_b)
        (cfg.alarm_enable && fault_report_only && !fault_actionable)
            |=> fault_indicator_n && alarm_out;
    endproperty
    a_ro: assert property (p_ro) else $error("report-only wrong");
    property p_mon;
        @(posedge clk) disable iff (!rst_b)
        !pwm_tick |=> $stable(monitor_output_one) && $stable(monitor_output_two);
    endproperty
    a_mon: assert property (p_mon) else $error("monitor changed off tick");
    property p_ho;
        @(posedge clk) disable iff (!rst_b)
        regulator.handover_on |-> cfg.regulator_voltage_select[1];
    endproperty
    a_ho: assert property (p_ho) else $error("handover at low voltage");
    c_brake: cover property (@(posedge clk) st_ff == ST_SLOW ##1 st_ff == ST_BRAKE);
    c_coast: cover property (@(posedge clk) st_ff == ST_COAST ##1 drive.restart);
    c_alarm: cover property (@(posedge clk) alarm_out && !fault_indicator_n);
endmodule

/* File: design/motor_pins_pkg.sv */
// Package for the motor pin control front end.
// Assumes a single 25 MHz core clock.
package motor_pins_pkg;

    localparam int CLK_HZ = 25_000_000;
    localparam int PWM_HZ = 25_000;
    localparam int PWM_CYCLES = CLK_HZ / PWM_HZ;
    localparam logic [9:0] PWM_CYCLES_W = 10'(PWM_CYCLES - 1);

    localparam logic [1:0] VSEL_3V3 = 2'h0;
    localparam logic [1:0] VSEL_4V0 = 2'h1;
    localparam logic [1:0] VSEL_5V0 = 2'h2;
    localparam logic [1:0] VSEL_5V7 = 2'h3;
    localparam logic [15:0] ILIM_HI_MA = 16'h0258;
    localparam logic [15:0] ILIM_LO_MA = 16'h0096;
    localparam logic [7:0] SPEED_RST = 8'h00;
    localparam logic [7:0] MON_RST = 8'h00;

    typedef enum logic [1:0] {ST_RUN, ST_SLOW, ST_BRAKE, ST_COAST} drive_state_t;

    typedef struct packed {
        logic brake_ovr_en;
        logic brake_ovr;
        logic dir_ovr_en;
        logic dir_ovr;
        logic brake_align;
        logic [7:0] brake_speed_limit;
        logic alarm_enable;
        logic [1:0] regulator_voltage_select;
        logic regulator_current_limit_select;
        logic supply_handover_disable;
        logic [1:0] monitor_one_variable_address;
        logic [1:0] monitor_two_variable_address;
    } cfg_t;

    typedef struct packed {
        logic low_side_brake;
        logic align_brake;
        logic coast;
        logic restart;
        logic [2:0] phase_high;
    } drive_t;

    typedef struct packed {
        logic [1:0] buck_vout;
        logic [15:0] buck_ilim_ma;
        logic handover_on;
    } reg_t;

endpackage

/* File: dv/pin_source_model.sv */
// Model of the external controller that drives the motor control pins.
// Assumes the bench calls drive_pins; levels change on falling clock edges.
`timescale 1ns/1ns
module pin_source_model (
    // Clock
    input wire logic clk,
    // Pins toward the block
    output logic brake_pin,
    output logic dir_pin,
    output logic drive_disable_input,
    output logic speed_wake_active,
    output logic [7:0] speed_cmd
);
    initial begin
        brake_pin = 1'b0;
        dir_pin = 1'b1;
        drive_disable_input = 1'b0;
        speed_wake_active = 1'b1;
        speed_cmd = 8'h00;
    end

    // Levels move off the core sampling edge, on the falling edge half a cycle away from it
    task automatic drive_pins(input logic b, input logic d, input logic off, input logic [7:0] s);
        @(negedge clk);
        brake_pin = b;
        dir_pin = d;
        drive_disable_input = off;
        speed_cmd = s;
    endtask

    // Speed/wake level, also moved off the sampling edge
    task automatic set_wake(input logic w);
        @(negedge clk);
        speed_wake_active = w;
    endtask
endmodule

/* File: dv/tb_motor_pin_control.sv */
// Self-checking bench for the motor pin control front end.
// Assumes motor_pins_pkg and a 25 MHz core clock.
`timescale 1ns/1ns
module tb_motor_pin_control;
    import motor_pins_pkg::*;
    typedef struct {int k; logic [23:0] v;} note_t;
    logic clk, rst_b, brake_pin, dir_pin, drive_disable_input, speed_wake_active;
    logic [7:0] speed_cmd, motor_speed, duty_out, speed_out;
    logic [7:0] monitor_output_one, monitor_output_two;
    logic fault_actionable, fault_report_only, sleep_req, wake_req, speed_pulse_output;
    logic fault_indicator_n, alarm_out, alarm_oe;
    logic [2:0] ref_ph;
    cfg_t cfg;
    drive_t drive;
    reg_t regulator;
    note_t notes[$];
    note_t n;
    event note_ev;
    int pulses[2];
    logic fg_prev;
    int n_fail = 0;
    int total_checks = 0;
    integer seed = 32'hcbf3;
    string kind_name[7] = '{"regulator", "phase", "drive_mode", "fault_pins", "monitors",
                            "sleep_wake", "brake_speed"};

    pin_source_model pin_source_model_i (.clk(clk), .brake_pin(brake_pin), .dir_pin(dir_pin),
        .drive_disable_input(drive_disable_input), .speed_wake_active(speed_wake_active),
        .speed_cmd(speed_cmd));

    motor_pin_control motor_pin_control_i (.clk(clk), .rst_b(rst_b), .brake_pin(brake_pin),
        .dir_pin(dir_pin), .drive_disable_input(drive_disable_input),
        .speed_wake_active(speed_wake_active), .speed_cmd(speed_cmd), .cfg(cfg),
        .motor_speed(motor_speed), .duty_out(duty_out), .fault_actionable(fault_actionable),
        .fault_report_only(fault_report_only), .drive(drive), .speed_out(speed_out),
        .sleep_req(sleep_req), .wake_req(wake_req), .monitor_output_one(monitor_output_one),
        .monitor_output_two(monitor_output_two), .speed_pulse_output(speed_pulse_output),
        .fault_indicator_n(fault_indicator_n), .alarm_out(alarm_out), .alarm_oe(alarm_oe),
        .regulator(regulator));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [23:0] got(input int k);
        case (k)
            0: return 24'({regulator.buck_vout, regulator.buck_ilim_ma, regulator.handover_on});
            1: return 24'(drive.phase_high);
            2: return 24'({drive.coast, drive.low_side_brake, drive.align_brake});
            3: return 24'({fault_indicator_n, alarm_out & alarm_oe, alarm_oe});
            4: return 24'({monitor_output_one, monitor_output_two});
            5: return 24'({sleep_req, wake_req});
            default: return 24'(speed_out <= cfg.brake_speed_limit);
        endcase
    endfunction

    function automatic logic cond(input int c);
        case (c)
            0: return drive.low_side_brake | drive.align_brake;
            1: return !(drive.low_side_brake | drive.align_brake);
            2: return drive.restart;
            default: return drive.phase_high !== ref_ph;
        endcase
    endfunction

    task automatic final_report();
        $display("Checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    // Watcher compares while the caller waits for the next falling edge
    task automatic note(input int k, input logic [23:0] v);
        notes.push_back('{k, v});
        -> note_ev;
        @(negedge clk);
    endtask

    // Bounded wait on an output condition, counted as a comparison
    task automatic wait_on(input int c, input int lim);
        int i;
        i = 0;
        while (cond(c) !== 1'b1 && i < lim) begin
            @(posedge clk);
            #1;
            i++;
        end
        cmp("wait_condition", 24'h1, 24'(cond(c)));
        if (cond(c) !== 1'b1) begin
            final_report();
        end
        @(negedge clk);
    endtask

    // Watcher takes the oldest note and compares it with the outputs
    initial begin
        forever begin
            @(note_ev);
            while (notes.size() > 0) begin
                n = notes.pop_front();
                cmp(kind_name[n.k], n.v, got(n.k));
            end
        end
    end

    initial begin
        rst_b = 1'b0;
        cfg = '0;
        motor_speed = 8'h00;
        duty_out = 8'h00;
        fault_actionable = 1'b0;
        fault_report_only = 1'b0;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 16; i++) begin
            cfg.regulator_voltage_select = i[1:0];
            cfg.regulator_current_limit_select = i[2];
            cfg.supply_handover_disable = i[3];
            #1;
            note(0, 24'({i[1:0], i[2] ? ILIM_LO_MA : ILIM_HI_MA, !i[3] && i[1]}));
            @(negedge clk);
        end
        $display("test regulator done");
        pin_source_model_i.drive_pins(1'b0, 1'b1, 1'b1, 8'h20);
        repeat (4) @(negedge clk);
        note(2, 24'h4);
        note(1, 24'h0);
        note(5, 24'h1);
        pin_source_model_i.drive_pins(1'b0, 1'b1, 1'b0, 8'h40);
        wait_on(2, 8);
        pin_source_model_i.set_wake(1'b0);
        #1;
        note(5, 24'h2);
        pin_source_model_i.set_wake(1'b1);
        $display("test coast and wake done");
        for (int a = 0; a < 2; a++) begin
            cfg.brake_align = a[0];
            cfg.brake_speed_limit = 8'h10;
            pin_source_model_i.drive_pins(1'b1, 1'b1, 1'b0, 8'h40);
            wait_on(0, 300);
            note(6, 24'h1);
            note(2, a[0] ? 24'h1 : 24'h2);
            repeat (20) @(negedge clk);
            note(2, a[0] ? 24'h1 : 24'h2);
            pin_source_model_i.drive_pins(1'b0, 1'b1, 1'b0, 8'h40);
            wait_on(1, 8);
        end
        cfg.brake_ovr_en = 1'b1;
        cfg.brake_ovr = 1'b1;
        wait_on(0, 300);
        cfg.brake_ovr = 1'b0;
        wait_on(1, 8);
        cfg.brake_ovr_en = 1'b0;
        $display("test brake done");
        for (int d = 0; d < 3; d++) begin
            cfg.dir_ovr_en = (d == 2);
            pin_source_model_i.drive_pins(1'b0, d != 1, 1'b0, 8'h40);
            repeat (5) @(negedge clk);
            ref_ph = drive.phase_high;
            wait_on(3, 2100);
            if (d != 0) begin
                note(1, 24'({ref_ph[0], ref_ph[2:1]}));
            end else begin
                note(1, 24'({ref_ph[1:0], ref_ph[2]}));
            end
        end
        cfg.dir_ovr_en = 1'b0;
        $display("test direction done");
        for (int i = 0; i < 8; i++) begin
            cfg.alarm_enable = i[0];
            fault_actionable = i[1];
            fault_report_only = i[2];
            repeat (3) @(negedge clk);
            note(3, 24'({i[0] ? !i[1] : !(i[1] | i[2]), i[0] & (i[1] | i[2]), i[0]}));
        end
        fault_actionable = 1'b0;
        fault_report_only = 1'b0;
        $display("test faults done");
        cfg.monitor_one_variable_address = 2'h1;
        cfg.monitor_two_variable_address = 2'h2;
        motor_speed = 8'($random(seed));
        duty_out = 8'($random(seed));
        repeat (2100) @(negedge clk);
        note(4, 24'({motor_speed, duty_out}));
        cfg.monitor_one_variable_address = 2'h0;
        cfg.monitor_two_variable_address = 2'h3;
        repeat (2100) @(negedge clk);
        note(4, 24'({speed_cmd, 8'(ST_RUN)}));
        repeat (2) @(negedge clk);
        $display("test monitors done");
        // Whole accumulator turns per window, so edge counts are exact
        for (int s = 0; s < 2; s++) begin
            motor_speed = (s == 0) ? 8'h40 : 8'h80;
            repeat (2) @(negedge clk);
            pulses[s] = 0;
            for (int c = 0; c < 4096; c++) begin
                fg_prev = speed_pulse_output;
                @(negedge clk);
                if (speed_pulse_output && !fg_prev) begin
                    pulses[s]++;
                end
            end
        end
        cmp("speed_pulse_ratio", 24'(2 * pulses[0]), 24'(pulses[1]));
        cmp("speed_pulse_seen", 24'h1, 24'(pulses[0] > 0));
        $display("test speed pulses done");
        final_report();
    end
endmodule
